// >>> logic/swlck_pkg.sv
// Purpose: Shared types and constants for the switch lock controller.
// Assumes: One upstream port (index 0) and a small number of downstream ports.
// Notes:   TLP kinds are abstracted to a few codes that the lock logic cares about.
`default_nettype none
package swlck_pkg;
  localparam int unsigned SWLCK_NUM_PORTS = 3;
  localparam int unsigned SWLCK_PORT_W    = 2;
  localparam int unsigned SWLCK_UP_PORT   = 0;
  localparam int unsigned SWLCK_STS_W     = 8;
  localparam int unsigned SWLCK_LOCKED_BIT = 0;
  localparam int unsigned SWLCK_DNLOCK_BIT = 1;
  localparam int unsigned SWLCK_PORT_LSB  = 2;
  localparam logic [7:0]  SWLCK_STS_RESET = 8'h00;
  localparam logic [1:0]  SWLCK_PORT_NONE = 2'h3;

  typedef enum logic [2:0] {
    SWLCK_TLP_MWR    = 3'h0,
    SWLCK_TLP_MRDLK  = 3'h1,
    SWLCK_TLP_CPLDLK = 3'h2,
    SWLCK_TLP_CPLLK  = 3'h3,
    SWLCK_TLP_UNLOCK = 3'h4,
    SWLCK_TLP_MSG    = 3'h5,
    SWLCK_TLP_OTHER  = 3'h6
  } swlck_tlp_type;

  typedef enum logic [3:0] {
    SWLCK_IDLE   = 4'b0001,
    SWLCK_DNLOCK = 4'b0010,
    SWLCK_LOCKED = 4'b0100,
    SWLCK_FAILED = 4'b1000
  } swlck_state_type;
endpackage
`default_nettype wire

// >>> logic/swlck_if.sv
// Purpose: Carrier between the switch lock controller and the root side.
// Assumes: One TLP header event per cycle on each direction, valid/ready handshake.
// Notes:   Root issues requests; switch returns completions and forwards locks.
`default_nettype none
interface swlck_if
  import swlck_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst
);
  // Root to switch upstream port.
  logic          req_valid;
  logic          req_ready;
  swlck_tlp_type req_type;
  logic [1:0]    req_port;
  // Switch to root completions.
  logic          cpl_valid;
  logic          cpl_ready;
  swlck_tlp_type cpl_type;

  modport dev
  (
    input  ref_clk, nrst, req_valid, req_type, req_port, cpl_ready,
    output req_ready, cpl_valid, cpl_type
  );
  modport root
  (
    input  ref_clk, nrst, req_ready, cpl_valid, cpl_type,
    output req_valid, req_type, req_port, cpl_ready
  );
endinterface
`default_nettype wire

// >>> logic/swlck_gate.sv
// Purpose: Per-port blocking gate for downstream-originated TLPs.
// Assumes: Source logic holds a TLP stable while its ready is low.
// Notes:   Blocked TLPs are held, never dropped; timeouts live elsewhere.
`default_nettype none
module swlck_gate
  import swlck_pkg::*;
(
  // Source side.
  input  wire logic       src_valid,
  output logic            src_ready,
  input  wire logic [1:0] src_port,
  input  wire logic [1:0] dst_port,
  // Lock state.
  input  wire logic       dn_locked,
  input  wire logic       sw_locked,
  input  wire logic [1:0] lock_port,
  // Fabric side.
  output logic            fab_valid,
  input  wire logic       fab_ready
);
  logic blocked;

  always_comb
  begin
    blocked = 1'b0;
    // A downstream lock only shields the locked port itself.
    if ((dn_locked || sw_locked) && dst_port == lock_port && src_port != lock_port)
    begin
      blocked = 1'b1;
    end
    if (sw_locked && dst_port == SWLCK_PORT_W'(SWLCK_UP_PORT) && src_port != lock_port)
    begin
      blocked = 1'b1;
    end
  end

  // Holding ready low keeps the TLP in its source queue.
  assign fab_valid = src_valid && !blocked;
  assign src_ready = fab_ready && !blocked;
endmodule
`default_nettype wire

// >>> logic/swlck_dev.sv
// Purpose: Lock sequence controller of the switch, root-facing end.
// Assumes: Posted-queue empty flags come from the port queues on ref_clk.
// Notes:   Status word is exported for the sideband management slave.
`default_nettype none
module swlck_dev
  import swlck_pkg::*;
#(
  parameter int unsigned NUM_PORTS = SWLCK_NUM_PORTS
)
(
  // Root link.
  swlck_if.dev            up,
  // Posted queue state.
  input  wire logic [NUM_PORTS-1:0] posted_empty_dn,
  input  wire logic [NUM_PORTS-1:0] posted_empty_up,
  // Forward to downstream port.
  output logic            fwd_valid,
  input  wire logic       fwd_ready,
  output swlck_tlp_type   fwd_type,
  output logic [1:0]      fwd_port,
  // Completions from downstream.
  input  wire logic       dcpl_valid,
  output logic            dcpl_ready,
  input  wire swlck_tlp_type dcpl_type,
  input  wire logic [1:0] dcpl_port,
  // Downstream-originated traffic.
  input  wire logic       dtlp_valid,
  output logic            dtlp_ready,
  input  wire logic [1:0] dtlp_src,
  input  wire logic [1:0] dtlp_dst,
  output logic            dtlp_fab_valid,
  input  wire logic       dtlp_fab_ready,
  // Message insertion.
  input  wire logic       msg_valid,
  output logic            msg_ready,
  // Sideband management.
  input  wire logic       mgmt_rd,
  output logic [7:0]      mgmt_rdata,
  output logic [7:0]      switch_status_word,
  output logic            switch_locked_flag
);
  swlck_state_type state_q;
  swlck_state_type state_d;
  logic [1:0]      lock_port_q;
  logic [1:0]      lock_port_d;
  logic [7:0]      rdata_q;
  logic            cpl_pend_q;
  swlck_tlp_type   cpl_type_q;
  logic            req_go;
  logic            cpl_go;
  logic            posted_ok;

  function automatic logic port_empty(input logic [NUM_PORTS-1:0] v, input logic [1:0] p);
    port_empty = (32'(p) < NUM_PORTS) ? v[p] : 1'b1;
  endfunction

  // A lock read or Unlock may pass only once posted traffic ahead of it has drained; other requests pass at once.
  always_comb
  begin
    posted_ok = 1'b1;
    unique case (up.req_type)
      SWLCK_TLP_MRDLK:  posted_ok = port_empty(posted_empty_dn, up.req_port);
      SWLCK_TLP_UNLOCK: posted_ok = &posted_empty_dn;
      default:          posted_ok = 1'b1;
    endcase
  end

  // A new lock read to another port while a sequence is active is refused.
  logic seq_conflict;
  assign seq_conflict = (state_q != SWLCK_IDLE) && up.req_type == SWLCK_TLP_MRDLK
                        && up.req_port != lock_port_q;

  assign fwd_valid = up.req_valid && posted_ok && !seq_conflict;
  assign fwd_type  = up.req_type;
  assign fwd_port  = (up.req_type == SWLCK_TLP_UNLOCK) ? lock_port_q : up.req_port;
  assign up.req_ready = fwd_ready && posted_ok && !seq_conflict;
  assign req_go    = up.req_valid && up.req_ready;

  // Completion returns to root; locked completion waits on upstream posted writes.
  assign dcpl_ready = !cpl_pend_q && port_empty(posted_empty_up, dcpl_port);
  assign cpl_go     = dcpl_valid && dcpl_ready;
  assign up.cpl_valid = cpl_pend_q;
  assign up.cpl_type  = cpl_type_q;

  always_ff @(posedge up.ref_clk or negedge up.nrst)
  begin
    if (!up.nrst)
    begin
      cpl_pend_q <= 1'b0;
      cpl_type_q <= SWLCK_TLP_CPLLK;
    end
    else if (cpl_go)
    begin
      cpl_pend_q <= 1'b1;
      cpl_type_q <= dcpl_type;
    end
    else if (up.cpl_ready)
    begin
      cpl_pend_q <= 1'b0;
    end
  end

  always_comb
  begin
    state_d     = state_q;
    lock_port_d = lock_port_q;
    if (req_go && up.req_type == SWLCK_TLP_UNLOCK)
    begin
      state_d     = SWLCK_IDLE;
      lock_port_d = SWLCK_PORT_NONE;
    end
    else
    begin
      unique case (state_q)
        SWLCK_IDLE:
        begin
          if (req_go && up.req_type == SWLCK_TLP_MRDLK)
          begin
            state_d     = SWLCK_DNLOCK;
            lock_port_d = up.req_port;
          end
        end
        SWLCK_DNLOCK:
        begin
          if (cpl_go && dcpl_port == lock_port_q)
          begin
            state_d = (dcpl_type == SWLCK_TLP_CPLDLK) ? SWLCK_LOCKED : SWLCK_FAILED;
          end
        end
        // Reads, writes and completions do not move a held lock.
        SWLCK_LOCKED: state_d = SWLCK_LOCKED;
        SWLCK_FAILED: state_d = SWLCK_FAILED;
        default:
        begin
          state_d     = SWLCK_IDLE;
          lock_port_d = SWLCK_PORT_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge up.ref_clk or negedge up.nrst)
  begin
    if (!up.nrst)
    begin
      state_q     <= SWLCK_IDLE;
      lock_port_q <= SWLCK_PORT_NONE;
    end
    else
    begin
      state_q     <= state_d;
      lock_port_q <= lock_port_d;
    end
  end

  swlck_gate u_gate
  (
    .src_valid (dtlp_valid),
    .src_ready (dtlp_ready),
    .src_port  (dtlp_src),
    .dst_port  (dtlp_dst),
    .dn_locked (state_q == SWLCK_DNLOCK || state_q == SWLCK_FAILED),
    .sw_locked (state_q == SWLCK_LOCKED),
    .lock_port (lock_port_q),
    .fab_valid (dtlp_fab_valid),
    .fab_ready (dtlp_fab_ready)
  );

  // Message insertion is never gated by lock state.
  assign msg_ready = msg_valid;

  assign switch_locked_flag = (state_q == SWLCK_LOCKED);
  always_comb
  begin
    switch_status_word                   = SWLCK_STS_RESET;
    switch_status_word[SWLCK_LOCKED_BIT] = switch_locked_flag;
    switch_status_word[SWLCK_DNLOCK_BIT] = (state_q != SWLCK_IDLE);
    switch_status_word[SWLCK_PORT_LSB +: 2] = lock_port_q;
  end

  // Sideband reads ignore lock state entirely.
  always_ff @(posedge up.ref_clk or negedge up.nrst)
  begin
    if (!up.nrst)
    begin
      rdata_q <= SWLCK_STS_RESET;
    end
    else if (mgmt_rd)
    begin
      rdata_q <= switch_status_word;
    end
  end
  assign mgmt_rdata = rdata_q;
endmodule
`default_nettype wire

// >>> logic/swlck_root.sv
// Purpose: Root-side end that runs lock sequences on the link.
// Assumes: User issues one command at a time and waits for done.
// Notes:   Only legal request types are sent while a lock is held.
`default_nettype none
module swlck_root
  import swlck_pkg::*;
(
  // Link.
  swlck_if.root           dn,
  // User commands.
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire swlck_tlp_type cmd_type,
  input  wire logic [1:0] cmd_port,
  // Results.
  output logic            cpl_seen,
  output swlck_tlp_type   cpl_type,
  output logic            lock_active
);
  logic          busy_q;
  swlck_tlp_type type_q;
  logic [1:0]    port_q;
  logic          active_q;
  logic [1:0]    lport_q;
  logic          seen_q;
  swlck_tlp_type ctype_q;
  logic          legal;

  // Refuse illegal requests while a sequence is open.
  always_comb
  begin
    legal = 1'b1;
    if (active_q)
    begin
      legal = (cmd_type == SWLCK_TLP_MWR || cmd_type == SWLCK_TLP_MRDLK
               || cmd_type == SWLCK_TLP_UNLOCK) && (cmd_type == SWLCK_TLP_UNLOCK
               || cmd_port == lport_q);
    end
  end
  assign cmd_ready    = !busy_q && legal;
  assign dn.req_valid = busy_q;
  assign dn.req_type  = type_q;
  assign dn.req_port  = port_q;
  assign dn.cpl_ready = 1'b1;

  always_ff @(posedge dn.ref_clk or negedge dn.nrst)
  begin
    if (!dn.nrst)
    begin
      busy_q <= 1'b0;
      type_q <= SWLCK_TLP_MWR;
      port_q <= 2'h0;
    end
    else if (cmd_valid && cmd_ready)
    begin
      busy_q <= 1'b1;
      type_q <= cmd_type;
      port_q <= cmd_port;
    end
    else if (dn.req_ready)
    begin
      busy_q <= 1'b0;
    end
  end

  // Sequence tracking; closed only by an Unlock.
  always_ff @(posedge dn.ref_clk or negedge dn.nrst)
  begin
    if (!dn.nrst)
    begin
      active_q <= 1'b0;
      lport_q  <= 2'h0;
    end
    else if (busy_q && dn.req_ready)
    begin
      if (type_q == SWLCK_TLP_UNLOCK)
      begin
        active_q <= 1'b0;
      end
      else if (type_q == SWLCK_TLP_MRDLK)
      begin
        active_q <= 1'b1;
        lport_q  <= port_q;
      end
    end
  end

  always_ff @(posedge dn.ref_clk or negedge dn.nrst)
  begin
    if (!dn.nrst)
    begin
      seen_q  <= 1'b0;
      ctype_q <= SWLCK_TLP_CPLLK;
    end
    else
    begin
      seen_q <= dn.cpl_valid;
      if (dn.cpl_valid)
      begin
        ctype_q <= dn.cpl_type;
      end
    end
  end
  assign cpl_seen    = seen_q;
  assign cpl_type    = ctype_q;
  assign lock_active = active_q;
endmodule
`default_nettype wire

// >>> sim/swlck_assertions.sv
// Purpose: Link assertions between the lock controller and the root end.
// Assumes: One clock; nrst is asynchronous and active low.
// Notes:   Helper flops mirror the open lock sequence seen on the link.
`default_nettype none
module swlck_assertions
  import swlck_pkg::*;
(
  // Clock and reset.
  input wire logic          ref_clk,
  input wire logic          nrst,
  // Link.
  input wire logic          req_valid,
  input wire logic          req_ready,
  input wire swlck_tlp_type req_type,
  input wire logic [1:0]    req_port,
  input wire logic          cpl_valid,
  input wire logic          cpl_ready,
  input wire swlck_tlp_type cpl_type
);
  logic       rd, ul, seq_q;
  logic [1:0] port_q, pend_q;
  assign rd = req_valid && req_ready && req_type == SWLCK_TLP_MRDLK;
  assign ul = req_valid && req_ready && req_type == SWLCK_TLP_UNLOCK;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      seq_q <= 1'b0;
    else if (rd || ul)
      seq_q <= rd;
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      port_q <= SWLCK_PORT_NONE;
    else if (rd && !seq_q)
      port_q <= req_port;
  end
  // Reads still owed an answer; a stray completion shows up here.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pend_q <= 2'h0;
    else
      pend_q <= pend_q + 2'(rd) - 2'(cpl_valid && cpl_ready);
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_req_held: assert property (
    req_valid && !req_ready |=> req_valid && $stable(req_port)) else $error("request dropped");
  a_one_sequence: assert property (
    seq_q && rd && req_port != port_q |-> 1'b0) else $error("second lock taken");
  a_lock_types: assert property (
    seq_q && req_valid |-> req_type inside {SWLCK_TLP_MWR, SWLCK_TLP_MRDLK, SWLCK_TLP_UNLOCK})
    else $error("illegal request while locked");
  a_cpl_kind: assert property (
    cpl_valid |-> cpl_type inside {SWLCK_TLP_CPLDLK, SWLCK_TLP_CPLLK}) else $error("bad kind");
  a_cpl_owed: assert property (cpl_valid |-> pend_q != 2'h0)
    else $error("completion without read");
  a_cpl_once: assert property (cpl_valid && cpl_ready |=> !cpl_valid)
    else $error("completion repeated");
  a_unlock_quiet: assert property (ul |=> !cpl_valid [*2])
    else $error("completion after unlock");
  a_reset_idle: assert property ($rose(nrst) |-> !req_valid && !cpl_valid)
    else $error("link busy after reset");
  c_lock_ok: cover property (cpl_valid && cpl_type == SWLCK_TLP_CPLDLK);
  c_lock_fail: cover property (cpl_valid && cpl_type == SWLCK_TLP_CPLLK);
  c_unlock: cover property (ul);
endmodule
`default_nettype wire

// >>> sim/swlck_tb.sv
// Purpose: Self-checking bench for both ends of the switch lock controller.
// Assumes: Model states 0 idle, 1 port lock, 2 switch lock, 3 failed lock.
// Notes:   Inputs move 10 ns after each rising edge of ref_clk.
`default_nettype none
module swlck_tb
  import swlck_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          ref_clk, nrst, cmd_valid, cmd_ready, cpl_seen, fwd_valid, dcpl_valid;
  logic          dcpl_ready, dtlp_valid, dtlp_ready, fab_valid, msg_valid, msg_ready;
  logic          mgmt_rd, lk_flag, lk_act;
  logic [1:0]    fwd_port, dcpl_port, dtlp_src, dtlp_dst, cmd_port;
  logic [2:0]    pe_dn, pe_up;
  logic [7:0]    mgmt_rdata, sts, snap;
  swlck_tlp_type fwd_type, dcpl_type, cmd_type, cpl_type;
  int            failures = 0, comparisons = 0, seed = 15, m_st = 0, m_port = 3;
  swlck_if swlck_if_inst (.ref_clk(ref_clk), .nrst(nrst));
  swlck_dev swlck_dev_inst (.up(swlck_if_inst), .posted_empty_dn(pe_dn),
    .posted_empty_up(pe_up), .fwd_valid(fwd_valid), .fwd_ready(1'b1), .fwd_type(fwd_type),
    .fwd_port(fwd_port), .dcpl_valid(dcpl_valid), .dcpl_ready(dcpl_ready),
    .dcpl_type(dcpl_type), .dcpl_port(dcpl_port), .dtlp_valid(dtlp_valid),
    .dtlp_ready(dtlp_ready), .dtlp_src(dtlp_src), .dtlp_dst(dtlp_dst),
    .dtlp_fab_valid(fab_valid), .dtlp_fab_ready(1'b1), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .switch_status_word(sts), .switch_locked_flag(lk_flag));
  swlck_root swlck_root_inst (.dn(swlck_if_inst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_type(cmd_type), .cmd_port(cmd_port), .cpl_seen(cpl_seen),
    .cpl_type(cpl_type), .lock_active(lk_act));
  swlck_assertions swlck_assertions_inst (.ref_clk(ref_clk), .nrst(nrst),
    .req_valid(swlck_if_inst.req_valid), .req_ready(swlck_if_inst.req_ready),
    .req_type(swlck_if_inst.req_type), .req_port(swlck_if_inst.req_port),
    .cpl_valid(swlck_if_inst.cpl_valid), .cpl_ready(swlck_if_inst.cpl_ready),
    .cpl_type(swlck_if_inst.cpl_type));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #10;
  endtask
  // Samples at the edge itself, before that edge's updates land.
  task automatic await(input int k);
    logic [3:0] v;
    repeat (64)
    begin
      @(posedge ref_clk);
      snap = {2'h0, fwd_valid, fwd_type, fwd_port};
      v = {cmd_valid & cmd_ready, cpl_seen, dcpl_valid & dcpl_ready,
           swlck_if_inst.req_valid & swlck_if_inst.req_ready};
      if (v[k] === 1'b1)
      begin
        #10;
        return;
      end
    end
    failures++;
    $display("[ERR] handshake %0d expected 1 seen 0", k);
    summarize;
  endtask
  task automatic cmd(input swlck_tlp_type t, input logic [1:0] p);
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_port = p;
    await(3);
    cmd_valid = 1'b0;
    await(0);
    chk("forward", {2'h0, 1'b1, t, (t == SWLCK_TLP_UNLOCK) ? m_port[1:0] : p}, snap);
    if (t == SWLCK_TLP_MRDLK && m_st == 0)
      m_port = p;
    if (t == SWLCK_TLP_UNLOCK)
      m_st = 0;
    else if (t == SWLCK_TLP_MRDLK && m_st == 0)
      m_st = 1;
  endtask
  task automatic dcpl(input swlck_tlp_type t);
    dcpl_valid = 1'b1;
    dcpl_type = t;
    dcpl_port = m_port[1:0];
    await(1);
    dcpl_valid = 1'b0;
    await(2);
    chk("completion", {5'h00, t}, {5'h00, cpl_type});
    if (m_st == 1)
      m_st = (t == SWLCK_TLP_CPLDLK) ? 2 : 3;
  endtask
  task automatic status;
    logic [7:0] e;
    e = {4'h0, (m_st == 0) ? 2'h3 : m_port[1:0], 1'(m_st != 0), 1'(m_st == 2)};
    mgmt_rd = 1'b1;
    chk("status", e, sts);
    chk("flag", {7'h00, e[0]}, {7'h00, lk_flag});
    chk("active", {7'h00, 1'(m_st != 0)}, {7'h00, lk_act});
    tick;
    mgmt_rd = 1'b0;
    tick;
    chk("sideband", e, mgmt_rdata);
  endtask
  task automatic hold(input int k);
    repeat (4)
    begin
      tick;
      chk("stall", 8'h00, {7'h00, k ? dcpl_ready : swlck_if_inst.req_ready});
    end
    pe_dn = 3'h7;
    pe_up = 3'h7;
  endtask
  // Offers each route for one cycle; the gate holds no state, so a taken TLP changes nothing.
  task automatic sweep;
    logic b;
    for (int s = 1; s < 3; s++)
      for (int d = 0; d < 3; d++)
      begin
        b = m_st != 0 && s != m_port && (d == m_port || (m_st == 2 && d == 0));
        dtlp_src = 2'(s);
        dtlp_dst = 2'(d);
        dtlp_valid = 1'b1;
        msg_valid = 1'($random(seed));
        tick;
        chk("route", {5'h00, msg_valid, !b, !b}, {5'h00, msg_ready, dtlp_ready, fab_valid});
      end
    dtlp_valid = 1'b0;
    msg_valid = 1'b0;
    tick;
  endtask
  initial
  begin
    logic [1:0] p;
    {nrst, cmd_valid, dcpl_valid, dtlp_valid, msg_valid, mgmt_rd} = 6'h00;
    {cmd_port, dcpl_port, dtlp_src, dtlp_dst} = 8'h00;
    {pe_dn, pe_up} = 6'h3F;
    cmd_type = SWLCK_TLP_MWR;
    dcpl_type = SWLCK_TLP_CPLLK;
    repeat (20) tick;
    nrst = 1'b1;
    status;
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      p = 2'(1 + ($random(seed) & 1));
      pe_dn[p] = 1'b0;
      fork
        cmd(SWLCK_TLP_MRDLK, p);
        hold(0);
      join
      status;
      sweep;
      pe_up[p] = 1'b0;
      fork
        dcpl(i[0] ? SWLCK_TLP_CPLDLK : SWLCK_TLP_CPLLK);
        hold(1);
      join
      status;
      sweep;
      cmd(SWLCK_TLP_MWR, p);
      cmd(SWLCK_TLP_MRDLK, p);
      dcpl(SWLCK_TLP_CPLLK);
      status;
      pe_dn[3 - p] = 1'b0;
      fork
        cmd(SWLCK_TLP_UNLOCK, p);
        hold(0);
      join
      status;
      sweep;
      $display("lock round %0d done", i);
    end
    cmd(SWLCK_TLP_MRDLK, 2'h1);
    cmd_valid = 1'b1;
    cmd_port = 2'h2;
    repeat (5)
    begin
      tick;
      chk("conflict", 8'h00, {7'h00, swlck_if_inst.req_valid & swlck_if_inst.req_ready});
      chk("refused", 8'h00, {7'h00, cmd_ready});
    end
    cmd_type = SWLCK_TLP_OTHER;
    cmd_port = 2'h1;
    tick;
    chk("illegal", 8'h00, {7'h00, cmd_ready});
    nrst = 1'b0;
    cmd_valid = 1'b0;
    tick;
    nrst = 1'b1;
    m_st = 0;
    status;
    $display("conflict and reset test done");
    summarize;
  end
endmodule
`default_nettype wire
